// file: frbc_core.sv
// How it works
// - resume starts suspended operation within resume_time
// - resumed operation clears its suspend flag
// - busy while resumed operation runs
// - dual suspend: resume program first only
// - suspend command ignored while still resuming
// - 53h to buffer 1, 55h to buffer 2
// - transfer starts on chip select rising
// - busy readable during page_transfer_time
// - 60h compares buffer 1, 61h buffer 2
// - compare starts on chip select rising
// - busy throughout page_compare_time
// - compare outcome lands in status bit 6
// - block transfer/compare to program-suspended buffer
`timescale 1ns/1ps
`default_nettype none

module frbc_core
    import frbc_pkg::*;
#(
    parameter int unsigned RESUME_CYCLES = RESUME_CYC,   // resume_time in cycles
    parameter int unsigned XFER_CYCLES   = XFER_CYC,     // page_transfer_time in cycles
    parameter int unsigned CMP_CYCLES    = CMP_CYC,      // page_compare_time in cycles
    parameter logic [7:0]  OP_RESUME     = OP_RESUME_DEF, // resume opcode
    parameter logic [7:0]  OP_SUSPEND    = OP_SUSP_DEF    // suspend opcode
) (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // serial pins, sampled as synchronous
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    // suspend events from the suspend logic
    input  wire logic        set_buf1_suspend,
    input  wire logic        set_buf2_suspend,
    input  wire logic        set_erase_suspend,
    // array engine
    input  wire logic        op_done,
    input  wire logic        cmp_mismatch,
    output logic             resume_go,
    output frbc_pkg::frbc_tgt_t resume_target,
    output logic             suspend_go,
    output logic             xfer_go,
    output logic             cmp_go,
    output logic             buf_sel,
    output logic [23:0]      page_addr,
    // status
    output logic             buf1_program_suspended,
    output logic             buf2_program_suspended,
    output logic             erase_suspended_flag,
    output logic             ready,
    output logic             cmp_result,
    output logic [7:0]       status
);
    import frbc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic              sck_q;          // previous serial clock sample
    logic              cs_n_q;         // previous chip select sample
    logic [7:0]        shreg;          // byte being shifted in
    logic [2:0]        bit_cnt;        // bit position in byte
    logic [2:0]        byte_cnt;       // bytes received in frame
    logic [7:0]        opcode;         // first byte of frame
    logic [23:0]       addr;           // address bytes
    logic              sck_rise;       // serial clock rising edge
    logic              cs_rise;        // end of frame
    logic [7:0]        next_byte;      // byte including current bit
    frbc_state_t       state;          // controller state
    logic [CNT_W-1:0]  cnt;            // remaining cycles of a timed phase
    logic              clr_ps1;        // flag clear strobes
    logic              clr_ps2;
    logic              clr_es;
    logic              idle;
    logic              has_addr;       // opcode plus three address bytes arrived
    logic              do_resume;
    logic              do_suspend;
    logic              do_xfer;
    logic              do_cmp;
    logic              sel2;           // opcode names buffer 2
    logic              sel_blocked;    // selected buffer holds suspended program

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection on pins
    assign sck_rise  = sck & ~sck_q;
    assign cs_rise   = cs_n & ~cs_n_q;
    assign next_byte = {shreg[6:0], si};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_q  <= 1'b0;
            cs_n_q <= 1'b1;
        end else if (ce) begin
            sck_q  <= sck;
            cs_n_q <= cs_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame shifter: opcode then address bytes, msb first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shreg    <= 8'h00;
            bit_cnt  <= 3'h0;
            byte_cnt <= 3'h0;
            opcode   <= 8'h00;
            addr     <= 24'h000000;
        end else if (ce) begin
            if (cs_n) begin
                // frame closed: restart counting
                bit_cnt  <= 3'h0;
                byte_cnt <= 3'h0;
            end else if (sck_rise) begin
                shreg   <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST) begin
                    // whole byte taken
                    if (byte_cnt == 3'h0) begin
                        opcode <= next_byte;
                    end else if (byte_cnt <= ADDR_BYTES) begin
                        addr <= {addr[15:0], next_byte};
                    end
                    if (byte_cnt != BYTE_CNT_MAX) begin
                        byte_cnt <= byte_cnt + 3'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode at the end of a frame
    always_comb begin
        idle        = (state == FRBC_IDLE);
        has_addr    = (byte_cnt > ADDR_BYTES);
        sel2        = (opcode == OP_XFER_BUF2) || (opcode == OP_CMP_BUF2);
        sel_blocked = sel2 ? buf2_program_suspended : buf1_program_suspended;
        do_resume   = cs_rise && idle && (byte_cnt != 3'h0) && (opcode == OP_RESUME) &&
                      (buf1_program_suspended || buf2_program_suspended ||
                       erase_suspended_flag);
        // suspend honoured only while the resumed operation truly runs
        do_suspend  = cs_rise && (state == FRBC_RUNNING) && (byte_cnt != 3'h0) &&
                      (opcode == OP_SUSPEND);
        do_xfer     = cs_rise && idle && has_addr && !sel_blocked &&
                      ((opcode == OP_XFER_BUF1) || (opcode == OP_XFER_BUF2));
        do_cmp      = cs_rise && idle && has_addr && !sel_blocked &&
                      ((opcode == OP_CMP_BUF1) || (opcode == OP_CMP_BUF2));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // controller: timed phases and resumed run
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state         <= FRBC_IDLE;
            cnt           <= '0;
            resume_target <= FRBC_TGT_PROG1;
            resume_go     <= 1'b0;
            suspend_go    <= 1'b0;
            xfer_go       <= 1'b0;
            cmp_go        <= 1'b0;
            buf_sel       <= 1'b0;
            page_addr     <= 24'h000000;
        end else if (ce) begin
            resume_go  <= 1'b0;
            suspend_go <= 1'b0;
            xfer_go    <= 1'b0;
            cmp_go     <= 1'b0;
            case (state)
                FRBC_IDLE: begin
                    if (do_resume) begin
                        // program wins over erase when both are suspended
                        if (buf1_program_suspended) begin
                            resume_target <= FRBC_TGT_PROG1;
                        end else if (buf2_program_suspended) begin
                            resume_target <= FRBC_TGT_PROG2;
                        end else begin
                            resume_target <= FRBC_TGT_ERASE;
                        end
                        resume_go <= 1'b1;
                        cnt       <= CNT_W'(RESUME_CYCLES - 1);
                        state     <= FRBC_RESUMING;
                    end else if (do_xfer) begin
                        xfer_go   <= 1'b1;
                        buf_sel   <= sel2;
                        page_addr <= addr;
                        cnt       <= CNT_W'(XFER_CYCLES - 1);
                        state     <= FRBC_XFER;
                    end else if (do_cmp) begin
                        cmp_go    <= 1'b1;
                        buf_sel   <= sel2;
                        page_addr <= addr;
                        cnt       <= CNT_W'(CMP_CYCLES - 1);
                        state     <= FRBC_CMP;
                    end
                end
                FRBC_RESUMING: begin
                    // resume settles within resume_time
                    if (cnt == '0) begin
                        state <= FRBC_RUNNING;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                FRBC_RUNNING: begin
                    // busy until the array finishes or is suspended again
                    if (op_done) begin
                        state <= FRBC_IDLE;
                    end else if (do_suspend) begin
                        suspend_go <= 1'b1;
                        state      <= FRBC_IDLE;
                    end
                end
                FRBC_XFER, FRBC_CMP: begin
                    if (cnt == '0) begin
                        state <= FRBC_IDLE;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                default: begin
                    state <= FRBC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // suspend flags: cleared when resume settles, a set wins over a clear
    always_comb begin
        clr_ps1 = (state == FRBC_RESUMING) && (cnt == '0) &&
                  (resume_target == FRBC_TGT_PROG1);
        clr_ps2 = (state == FRBC_RESUMING) && (cnt == '0) &&
                  (resume_target == FRBC_TGT_PROG2);
        clr_es  = (state == FRBC_RESUMING) && (cnt == '0) &&
                  (resume_target == FRBC_TGT_ERASE);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            buf1_program_suspended <= 1'b0;
            buf2_program_suspended <= 1'b0;
            erase_suspended_flag   <= 1'b0;
        end else if (ce) begin
            buf1_program_suspended <= set_buf1_suspend  | (buf1_program_suspended & ~clr_ps1);
            buf2_program_suspended <= set_buf2_suspend  | (buf2_program_suspended & ~clr_ps2);
            erase_suspended_flag   <= set_erase_suspend | (erase_suspended_flag & ~clr_es);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare outcome: 1 on mismatch, held until the next compare ends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmp_result <= CMP_RST;
        end else if (ce) begin
            if ((state == FRBC_CMP) && (cnt == '0)) begin
                cmp_result <= cmp_mismatch;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status byte
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ready <= 1'b1;
        end else if (ce) begin
            ready <= (state == FRBC_IDLE) && !do_resume && !do_xfer && !do_cmp;
        end
    end

    always_comb begin
        status               = 8'h00;
        status[ST_READY_BIT] = ready;
        status[ST_CMP_BIT]   = cmp_result;
    end

endmodule : frbc_core

`default_nettype wire

// file: frbc_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// serial host that issues command frames
module frbc_host (
    // system clock
    input  wire logic clock,
    // serial pins toward the device
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // opcode then three address bytes, msb first, select low throughout
    task send(input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            @(negedge clock);
            cs_n = 1'b0;
            sck = 1'b0;
            si = d[i];
            @(negedge clock);
            sck = 1'b1;
        end
        @(negedge clock);
        sck = 1'b0;
        @(negedge clock);
        cs_n = 1'b1;
        si = ~si;  // released line shows no stale bit
    endtask : send
endmodule : frbc_host
`default_nettype wire

// file: frbc_pkg.sv
package frbc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    localparam int unsigned CLK_PERIOD_NS = 10;              // 100 MHz system clock

    ////////////////////////////////////////////////////////////////////////////////
    // opcodes
    localparam logic [7:0] OP_XFER_BUF1  = 8'h53;            // page to buffer 1
    localparam logic [7:0] OP_XFER_BUF2  = 8'h55;            // page to buffer 2
    localparam logic [7:0] OP_CMP_BUF1   = 8'h60;            // page compare with buffer 1
    localparam logic [7:0] OP_CMP_BUF2   = 8'h61;            // page compare with buffer 2
    localparam logic [7:0] OP_RESUME_DEF = 8'hE5;            // resume opcode default
    localparam logic [7:0] OP_SUSP_DEF   = 8'hE4;            // suspend opcode default

    ////////////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam logic [2:0] BIT_LAST      = 3'h7;             // last bit index of a byte
    localparam logic [2:0] ADDR_BYTES    = 3'h3;             // address bytes after opcode
    localparam logic [2:0] BYTE_CNT_MAX  = 3'h7;             // byte counter saturates here

    ////////////////////////////////////////////////////////////////////////////////
    // status byte layout
    localparam int unsigned ST_READY_BIT = 7;                // 1 = ready, 0 = busy
    localparam int unsigned ST_CMP_BIT   = 6;                // compare outcome
    localparam logic        CMP_RST      = 1'b0;             // compare bit after reset

    ////////////////////////////////////////////////////////////////////////////////
    // timing, in ns, then in cycles (longest times round down, at least one)
    localparam int unsigned RESUME_TIME_NS       = 40000;    // resume_time
    localparam int unsigned PAGE_TRANSFER_TIME_NS = 200000;  // page_transfer_time
    localparam int unsigned PAGE_COMPARE_TIME_NS  = 200000;  // page_compare_time
    localparam int unsigned RESUME_CYC   = (RESUME_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           RESUME_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned XFER_CYC     = (PAGE_TRANSFER_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           PAGE_TRANSFER_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned CMP_CYC      = (PAGE_COMPARE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           PAGE_COMPARE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W        = 24;               // width of the timer

    ////////////////////////////////////////////////////////////////////////////////
    // controller states and resume targets
    typedef enum logic [2:0] {
        FRBC_IDLE,
        FRBC_RESUMING,
        FRBC_RUNNING,
        FRBC_XFER,
        FRBC_CMP
    } frbc_state_t;

    typedef enum logic [1:0] {
        FRBC_TGT_PROG1,
        FRBC_TGT_PROG2,
        FRBC_TGT_ERASE
    } frbc_tgt_t;

endpackage : frbc_pkg

// file: frbc_props.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// port checker for the command core
module frbc_props
    import frbc_pkg::*;
#(
    parameter int unsigned RESUME_CYCLES = RESUME_CYC  // resume_time in cycles
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // serial select
    input wire logic       cs_n,
    // command pulses
    input wire logic       xfer_go,
    input wire logic       cmp_go,
    input wire logic       resume_go,
    input wire logic       suspend_go,
    input wire frbc_tgt_t  resume_target,
    input wire logic       buf_sel,
    // status
    input wire logic       buf1_program_suspended,
    input wire logic       buf2_program_suspended,
    input wire logic       erase_suspended_flag,
    input wire logic       ready,
    input wire logic       cmp_result,
    input wire logic [7:0] status
);
    int unsigned since_res;  // cycles since the last resume pulse, 0 before any
    // count from each resume pulse, saturating, so long deadlines need no wide delay range
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            since_res <= 0;
        end else if (resume_go) begin
            since_res <= 1;
        end else if (since_res != 0 && since_res != 32'hFFFFFFFF) begin
            since_res <= since_res + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_xfer_rise; xfer_go |-> $past(cs_n) && !$past(cs_n, 2); endproperty
    a_xfer_rise: assert property (p_xfer_rise) else $error("transfer off select rise");
    property p_cmp_rise; cmp_go |-> $past(cs_n) && !$past(cs_n, 2); endproperty
    a_cmp_rise: assert property (p_cmp_rise) else $error("compare off select rise");
    property p_xfer_busy; xfer_go |-> !ready [*8]; endproperty
    a_xfer_busy: assert property (p_xfer_busy) else $error("ready during transfer");
    property p_cmp_busy; cmp_go |-> !ready [*8]; endproperty
    a_cmp_busy: assert property (p_cmp_busy) else $error("ready during compare");
    property p_res_busy; resume_go |-> !ready [*8]; endproperty
    a_res_busy: assert property (p_res_busy) else $error("ready during resume");
    property p_status; status == {ready, cmp_result, 6'h00}; endproperty
    a_status: assert property (p_status) else $error("status layout");
    property p_cmp_hold; $changed(cmp_result) |-> !ready; endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare bit moved");
    property p_dual; resume_go && $past(erase_suspended_flag) && $past(buf1_program_suspended
        || buf2_program_suspended) |-> resume_target != FRBC_TGT_ERASE; endproperty
    a_dual: assert property (p_dual) else $error("erase resumed before program");
    property p_no_susp; suspend_go |-> since_res > RESUME_CYCLES; endproperty
    a_no_susp: assert property (p_no_susp) else $error("suspend while resuming");
    property p_clr; since_res == RESUME_CYCLES |-> ((resume_target == FRBC_TGT_ERASE) ?
        !erase_suspended_flag : (resume_target == FRBC_TGT_PROG2) ?
        !buf2_program_suspended : !buf1_program_suspended); endproperty
    a_clr: assert property (p_clr) else $error("suspend flag not cleared");
    property p_blocked; xfer_go || cmp_go |-> !(buf_sel ? $past(buf2_program_suspended)
        : $past(buf1_program_suspended)); endproperty
    a_blocked: assert property (p_blocked) else $error("suspended buffer used");
endmodule : frbc_props

bind frbc_core frbc_props #(.RESUME_CYCLES(RESUME_CYCLES)) i_frbc_props (
    .clock(clock), .rst(rst), .cs_n(cs_n), .xfer_go(xfer_go), .cmp_go(cmp_go),
    .resume_go(resume_go), .suspend_go(suspend_go), .resume_target(resume_target),
    .buf_sel(buf_sel), .buf1_program_suspended(buf1_program_suspended),
    .buf2_program_suspended(buf2_program_suspended),
    .erase_suspended_flag(erase_suspended_flag), .ready(ready),
    .cmp_result(cmp_result), .status(status));
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import frbc_pkg::*;
    localparam int unsigned RES = 100;  // shortened resume time, longer than a frame
    localparam int unsigned XFR = 12;   // shortened transfer and compare time
    logic        clock, rst, ce, op_done, cmp_mismatch, hit;
    logic        set_buf1_suspend, set_buf2_suspend, set_erase_suspend;
    wire logic   cs_n, sck, si;
    logic        resume_go, suspend_go, xfer_go, cmp_go, buf_sel, ready, cmp_result;
    logic        buf1_program_suspended, buf2_program_suspended, erase_suspended_flag;
    frbc_tgt_t   resume_target;
    logic [23:0] page_addr;
    logic [7:0]  status;
    int          num_errors, comparisons;
    ////////////////////////////////////////
    // design, host and clock
    frbc_core #(.RESUME_CYCLES(RES), .XFER_CYCLES(XFR), .CMP_CYCLES(XFR)) i_frbc_core (
        .clock(clock), .rst(rst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si),
        .set_buf1_suspend(set_buf1_suspend), .set_buf2_suspend(set_buf2_suspend),
        .set_erase_suspend(set_erase_suspend), .op_done(op_done),
        .cmp_mismatch(cmp_mismatch), .resume_go(resume_go), .resume_target(resume_target),
        .suspend_go(suspend_go), .xfer_go(xfer_go), .cmp_go(cmp_go), .buf_sel(buf_sel),
        .page_addr(page_addr), .buf1_program_suspended(buf1_program_suspended),
        .buf2_program_suspended(buf2_program_suspended),
        .erase_suspended_flag(erase_suspended_flag), .ready(ready),
        .cmp_result(cmp_result), .status(status));
    frbc_host i_frbc_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));
    always #(CLK_PERIOD_NS / 2) clock = ~clock;
    ////////////////////////////////////////
    // verdict and run end
    task end_sim();
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // look for a command pulse: 0 xfer, 1 cmp, 2 resume, 3 suspend
    task wait_go(input int k, input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++) begin
            @(negedge clock);
            hit = (k == 0) ? xfer_go : (k == 1) ? cmp_go : (k == 2) ? resume_go : suspend_go;
        end
    endtask : wait_go
    // bounded wait for a level: 0 ready, 1 buffer 1 flag, 2 erase flag, 3 buffer 2 flag
    task wait_lvl(input int k, input logic v, input int lim);
        logic s;
        for (int i = 0; i <= lim; i++) begin
            s = (k == 0) ? ready : (k == 1) ? buf1_program_suspended :
                (k == 2) ? erase_suspended_flag : buf2_program_suspended;
            if (s === v) return;
            @(negedge clock);
        end
        num_errors++;
        end_sim();
    endtask : wait_lvl
    // page command, accepted or refused
    task run_cmd(input logic [7:0] op, input logic [23:0] a, input logic ok, input logic mm);
        cmp_mismatch = mm;
        i_frbc_host.send({op, a});
        wait_go(int'(op[5]), 8);
        chk(hit, ok);
        if (ok) begin
            chk(buf_sel, (op == OP_XFER_BUF2) || (op == OP_CMP_BUF2));
            chk(page_addr, a);
            chk(ready, 1'b0);
            wait_lvl(0, 1'b1, XFR + 4);
            if (op[5]) chk(status, {1'b1, mm, 6'h00});
        end else begin
            chk(ready, 1'b1);
        end
    endtask : run_cmd
    ////////////////////////////////////////
    // main sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        op_done = 1'b0;
        cmp_mismatch = 1'b0;
        set_buf1_suspend = 1'b0;
        set_buf2_suspend = 1'b0;
        set_erase_suspend = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        chk(status, 8'h80);
        // every page command, compare both ways
        run_cmd(OP_XFER_BUF1, 24'h012345, 1'b1, 1'b0);
        run_cmd(OP_XFER_BUF2, 24'hABCDEF, 1'b1, 1'b0);
        run_cmd(OP_CMP_BUF1, 24'h00FF00, 1'b1, 1'b1);
        run_cmd(OP_CMP_BUF2, 24'h0F0F0F, 1'b1, 1'b0);
        // buffer 1 program and erase both suspended
        @(negedge clock);
        set_buf1_suspend = 1'b1;
        set_erase_suspend = 1'b1;
        @(negedge clock);
        set_buf1_suspend = 1'b0;
        set_erase_suspend = 1'b0;
        run_cmd(OP_XFER_BUF1, 24'h000100, 1'b0, 1'b0);
        run_cmd(OP_CMP_BUF1, 24'h000100, 1'b0, 1'b0);
        run_cmd(OP_CMP_BUF2, 24'h000200, 1'b1, 1'b1);
        // first resume picks the program, suspend is ignored meanwhile
        i_frbc_host.send({OP_RESUME_DEF, 24'h000000});
        wait_go(2, 8);
        chk(hit, 1'b1);
        chk(resume_target, FRBC_TGT_PROG1);
        i_frbc_host.send({OP_SUSP_DEF, 24'h000000});
        wait_go(3, 8);
        chk(hit, 1'b0);
        wait_lvl(1, 1'b0, RES);
        chk({ready, erase_suspended_flag}, 2'h1);
        op_done = 1'b1;
        @(negedge clock);
        op_done = 1'b0;
        wait_lvl(0, 1'b1, 4);
        // second resume restarts the erase; poll its flag before suspending
        i_frbc_host.send({OP_RESUME_DEF, 24'h000000});
        wait_go(2, 8);
        chk(resume_target, FRBC_TGT_ERASE);
        wait_lvl(2, 1'b0, RES);
        i_frbc_host.send({OP_SUSP_DEF, 24'h000000});
        wait_go(3, 8);
        chk(hit, 1'b1);
        wait_lvl(0, 1'b1, 4);
        // buffer 2 program suspended: held off while disabled, then the mirror case
        @(negedge clock);
        ce = 1'b0;
        set_buf2_suspend = 1'b1;
        @(negedge clock);
        chk(buf2_program_suspended, 1'b0);
        ce = 1'b1;
        @(negedge clock);
        set_buf2_suspend = 1'b0;
        chk(buf2_program_suspended, 1'b1);
        run_cmd(OP_XFER_BUF2, 24'h000300, 1'b0, 1'b0);
        run_cmd(OP_CMP_BUF2, 24'h000300, 1'b0, 1'b0);
        run_cmd(OP_XFER_BUF1, 24'h000400, 1'b1, 1'b0);
        i_frbc_host.send({OP_RESUME_DEF, 24'h000000});
        wait_go(2, 8);
        chk(hit, 1'b1);
        chk(resume_target, FRBC_TGT_PROG2);
        wait_lvl(3, 1'b0, RES);
        chk(ready, 1'b0);
        op_done = 1'b1;
        @(negedge clock);
        op_done = 1'b0;
        wait_lvl(0, 1'b1, 4);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
